// ### logic/fsl_defines.svh
`ifndef FSL_DEFINES_SVH
`define FSL_DEFINES_SVH

// Queue geometry, shared by both queues
`define FSL_DW          8
`define FSL_AW          3
`define FSL_PW          4
`define FSL_DEPTH       4'h8
`define FSL_PTR_ONE     4'h1
`define FSL_PTR_ZERO    4'h0
`define FSL_DATA_ZERO   8'h00

// Synchroniser stages, applied to both pointer directions
`define FSL_SYNC_N      2

// APB map
`define FSL_ADDR_W      12
`define FSL_CTRL_ADDR   12'h000
`define FSL_SC_ADDR     12'h004
`define FSL_DC_ADDR     12'h008
`define FSL_CTRL_W      5
`define FSL_CTRL_RESET  5'h00
`define FSL_BUS_ZERO    32'h0000_0000

`endif

// ### logic/fsl_pkg.sv
`default_nettype none
package fsl_pkg;

    typedef struct packed {
        logic le_storage;
        logic underflow_guard;
        logic overflow_guard;
        logic memory_output_reg_option;
        logic prefetch_output_select;
    } fsl_ctrl_t;

    typedef struct packed {
        logic       full;
        logic       empty;
        logic [3:0] used;
    } fsl_sc_stat_t;

    typedef struct packed {
        logic       rd_full;
        logic       rd_empty;
        logic [3:0] rd_used;
        logic       wr_full;
        logic       wr_empty;
        logic [3:0] wr_used;
    } fsl_dc_stat_t;

endpackage
`default_nettype wire

// ### logic/fsl_fifo_latency.sv
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "fsl_defines.svh"

// Summary of operation
// - Single-clock full flag follows an accepted write or read one cycle later.
// - Single-clock word count follows an accepted write or read one cycle later.
// - Normal mode: write clears empty in 2 (speed) or 1 (area); read 1.
// - Prefetch block memory: write shows empty and data in 3 or 2; read 1.
// - Logic storage: empty as block memory; prefetch write-to-data and reads 1 cycle.
// - Speed optimisation is the memory output register option set; area is clear.
// - Prefetch select clear gives normal mode; set shows head word before a read.
// - Dual-clock write updates write-side full and empty one write cycle later.
// - Dual-clock write updates write-side fill level two write cycles later.
// - Write reaches read-side full after 2 write plus n read cycles.
// - Write clears read-side empty after 2 write plus n read cycles.
// - Write reaches read-side fill level after 2 write plus n+1 read cycles.
// - Written data reaches read data after one write plus one read cycle.
// - Read updates read-side empty and full one read cycle later.
// - Read updates read-side fill level two read cycles later.
// - Read reaches write-side empty after 1 read plus n write cycles.
// - Read clears write-side full after 1 read plus n write cycles.
// - Read reaches write-side fill level after 1 read plus n+1 write cycles.
// - Dual-clock read shows the next word one read cycle later.
// - n equals the synchroniser stage count of the pipe depth setting.
// - Prefetch-only latencies apply only with prefetch output selected.
// - With guards on, writes while full and reads while empty are ignored.
module fsl_fifo_latency (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`FSL_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     sc_wr_req,
    input  wire logic [`FSL_DW-1:0]       sc_wr_data,
    input  wire logic                     sc_rd_req,
    output logic      [`FSL_DW-1:0]       sc_rd_data,
    output logic                          sc_full,
    output logic                          sc_empty,
    output logic      [`FSL_PW-1:0]       sc_used,
    input  wire logic                     dc_wr_req,
    input  wire logic [`FSL_DW-1:0]       dc_wr_data,
    output logic                          dc_wr_full,
    output logic                          dc_wr_empty,
    output logic      [`FSL_PW-1:0]       dc_wr_used,
    input  wire logic                     dc_rd_req,
    output logic      [`FSL_DW-1:0]       dc_rd_data,
    output logic                          dc_rd_full,
    output logic                          dc_rd_empty,
    output logic      [`FSL_PW-1:0]       dc_rd_used
);

    localparam int SN = `FSL_SYNC_N;
    localparam int DN = 1 << `FSL_AW;

    // ---------------- APB register file ----------------
    fsl_pkg::fsl_ctrl_t      ctrl;
    fsl_pkg::fsl_ctrl_t      next_ctrl;
    logic [31:0]             next_prdata;
    logic                    hit_ctrl;
    logic                    hit_sc;
    logic                    hit_dc;
    fsl_pkg::fsl_sc_stat_t   sc_stat;
    fsl_pkg::fsl_dc_stat_t   dc_stat;

    assign hit_ctrl = paddr == `FSL_CTRL_ADDR;
    assign hit_sc   = paddr == `FSL_SC_ADDR;
    assign hit_dc   = paddr == `FSL_DC_ADDR;
    // Zero wait states: read data is captured in the setup cycle
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~(hit_ctrl | hit_sc | hit_dc);
    assign sc_stat  = '{full: sc_full, empty: sc_empty, used: sc_used};
    assign dc_stat  = '{rd_full: dc_rd_full, rd_empty: dc_rd_empty, rd_used: dc_rd_used,
                        wr_full: dc_wr_full, wr_empty: dc_wr_empty, wr_used: dc_wr_used};

    always_comb begin
        next_ctrl   = ctrl;
        next_prdata = prdata;
        if (psel & penable & pwrite & hit_ctrl) begin
            next_ctrl = fsl_pkg::fsl_ctrl_t'(pwdata[`FSL_CTRL_W-1:0]);
        end
        if (psel & ~penable & ~pwrite) begin
            next_prdata = `FSL_BUS_ZERO;
            if (hit_ctrl) begin
                next_prdata[`FSL_CTRL_W-1:0] = ctrl;
            end else if (hit_sc) begin
                next_prdata[$bits(sc_stat)-1:0] = sc_stat;
            end else if (hit_dc) begin
                next_prdata[$bits(dc_stat)-1:0] = dc_stat;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl   <= fsl_pkg::fsl_ctrl_t'(`FSL_CTRL_RESET);
            prdata <= `FSL_BUS_ZERO;
        end else begin
            ctrl   <= next_ctrl;
            prdata <= next_prdata;
        end
    end

    // ---------------- Single-clock queue ----------------
    logic [`FSL_DW-1:0] sc_mem      [0:DN-1];
    logic [`FSL_DW-1:0] next_sc_mem [0:DN-1];
    logic [`FSL_PW-1:0] sc_wp;
    logic [`FSL_PW-1:0] sc_rp;
    logic [`FSL_PW-1:0] sc_wp_d1;
    logic [`FSL_PW-1:0] next_sc_wp;
    logic [`FSL_PW-1:0] next_sc_rp;
    logic [`FSL_PW-1:0] next_sc_used;
    logic [`FSL_PW-1:0] sc_view;
    logic               next_sc_full;
    logic               next_sc_empty;
    logic [`FSL_DW-1:0] next_sc_q;
    logic               sc_wr_acc;
    logic               sc_rd_acc;

    assign sc_wr_acc = sc_wr_req & ~(ctrl.overflow_guard & sc_full);
    assign sc_rd_acc = sc_rd_req & ~(ctrl.underflow_guard & sc_empty);

    always_comb begin
        next_sc_mem = sc_mem;
        if (sc_wr_acc) begin
            next_sc_mem[sc_wp[`FSL_AW-1:0]] = sc_wr_data;
        end
        next_sc_wp   = sc_wp + (sc_wr_acc ? `FSL_PTR_ONE : `FSL_PTR_ZERO);
        next_sc_rp   = sc_rp + (sc_rd_acc ? `FSL_PTR_ONE : `FSL_PTR_ZERO);
        next_sc_used = next_sc_wp - next_sc_rp;
        next_sc_full = next_sc_used == `FSL_DEPTH;
        // Empty sees the write pointer late by the mode's extra stages; reads act at once
        unique case ({ctrl.prefetch_output_select, ctrl.memory_output_reg_option})
            2'b00: sc_view = next_sc_wp;
            2'b01: sc_view = sc_wp;
            2'b10: sc_view = sc_wp;
            2'b11: sc_view = sc_wp_d1;
        endcase
        next_sc_empty = sc_view == next_sc_rp;
        next_sc_q     = sc_rd_data;
        if (!ctrl.prefetch_output_select) begin
            if (sc_rd_acc) begin
                next_sc_q = sc_mem[sc_rp[`FSL_AW-1:0]];
            end
        end else if (ctrl.le_storage | ~next_sc_empty) begin
            // Block memory holds the head back until empty clears; logic storage bypasses
            next_sc_q = sc_mem[next_sc_rp[`FSL_AW-1:0]];
            if (sc_wr_acc && sc_wp[`FSL_AW-1:0] == next_sc_rp[`FSL_AW-1:0]) begin
                next_sc_q = sc_wr_data;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DN; i++) begin
                sc_mem[i] <= `FSL_DATA_ZERO;
            end
            sc_wp      <= `FSL_PTR_ZERO;
            sc_rp      <= `FSL_PTR_ZERO;
            sc_wp_d1   <= `FSL_PTR_ZERO;
            sc_used    <= `FSL_PTR_ZERO;
            sc_full    <= 1'b0;
            sc_empty   <= 1'b1;
            sc_rd_data <= `FSL_DATA_ZERO;
        end else begin
            sc_mem     <= next_sc_mem;
            sc_wp      <= next_sc_wp;
            sc_rp      <= next_sc_rp;
            sc_wp_d1   <= sc_wp;
            sc_used    <= next_sc_used;
            sc_full    <= next_sc_full;
            sc_empty   <= next_sc_empty;
            sc_rd_data <= next_sc_q;
        end
    end

    // ---------------- Dual-clock queue ----------------
    // Both sides share pclk here; the pointer pipes reproduce the crossing latency.
    logic [`FSL_DW-1:0] dc_mem      [0:DN-1];
    logic [`FSL_DW-1:0] next_dc_mem [0:DN-1];
    logic [`FSL_PW-1:0] dc_wp;
    logic [`FSL_PW-1:0] dc_rp;
    logic [`FSL_PW-1:0] next_dc_wp;
    logic [`FSL_PW-1:0] next_dc_rp;
    logic [`FSL_PW-1:0] wp_pipe      [0:SN+1];
    logic [`FSL_PW-1:0] rp_pipe      [0:SN+1];
    logic [`FSL_PW-1:0] next_wp_pipe [0:SN+1];
    logic [`FSL_PW-1:0] next_rp_pipe [0:SN+1];
    logic [`FSL_PW-1:0] next_dc_wr_used;
    logic [`FSL_PW-1:0] next_dc_rd_used;
    logic               next_dc_wr_full;
    logic               next_dc_wr_empty;
    logic               next_dc_rd_full;
    logic               next_dc_rd_empty;
    logic [`FSL_DW-1:0] next_dc_q;
    logic               dc_wr_acc;
    logic               dc_rd_acc;

    assign dc_wr_acc = dc_wr_req & ~(ctrl.overflow_guard & dc_wr_full);
    assign dc_rd_acc = dc_rd_req & ~(ctrl.underflow_guard & dc_rd_empty);

    always_comb begin
        next_dc_mem = dc_mem;
        if (dc_wr_acc) begin
            next_dc_mem[dc_wp[`FSL_AW-1:0]] = dc_wr_data;
        end
        next_dc_wp = dc_wp + (dc_wr_acc ? `FSL_PTR_ONE : `FSL_PTR_ZERO);
        next_dc_rp = dc_rp + (dc_rd_acc ? `FSL_PTR_ONE : `FSL_PTR_ZERO);
        // Stage k holds a pointer k+1 cycles old; SN sets n in both directions
        next_wp_pipe[0] = next_dc_wp;
        next_rp_pipe[0] = next_dc_rp;
        for (int k = 1; k <= SN + 1; k++) begin
            next_wp_pipe[k] = wp_pipe[k-1];
            next_rp_pipe[k] = rp_pipe[k-1];
        end
        next_dc_wr_full  = (next_dc_wp - rp_pipe[SN-1]) == `FSL_DEPTH;
        next_dc_wr_empty = next_dc_wp == rp_pipe[SN-1];
        next_dc_wr_used  = dc_wp - rp_pipe[SN];
        next_dc_rd_full  = (wp_pipe[SN] - next_dc_rp) == `FSL_DEPTH;
        next_dc_rd_empty = wp_pipe[SN] == next_dc_rp;
        next_dc_rd_used  = wp_pipe[SN+1] - dc_rp;
        next_dc_q        = dc_rd_data;
        if (ctrl.prefetch_output_select) begin
            next_dc_q = dc_mem[next_dc_rp[`FSL_AW-1:0]];
        end else if (dc_rd_acc) begin
            next_dc_q = dc_mem[dc_rp[`FSL_AW-1:0]];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DN; i++) begin
                dc_mem[i] <= `FSL_DATA_ZERO;
            end
            for (int k = 0; k <= SN + 1; k++) begin
                wp_pipe[k] <= `FSL_PTR_ZERO;
                rp_pipe[k] <= `FSL_PTR_ZERO;
            end
            dc_wp       <= `FSL_PTR_ZERO;
            dc_rp       <= `FSL_PTR_ZERO;
            dc_wr_full  <= 1'b0;
            dc_wr_empty <= 1'b1;
            dc_wr_used  <= `FSL_PTR_ZERO;
            dc_rd_full  <= 1'b0;
            dc_rd_empty <= 1'b1;
            dc_rd_used  <= `FSL_PTR_ZERO;
            dc_rd_data  <= `FSL_DATA_ZERO;
        end else begin
            dc_mem      <= next_dc_mem;
            wp_pipe     <= next_wp_pipe;
            rp_pipe     <= next_rp_pipe;
            dc_wp       <= next_dc_wp;
            dc_rp       <= next_dc_rp;
            dc_wr_full  <= next_dc_wr_full;
            dc_wr_empty <= next_dc_wr_empty;
            dc_wr_used  <= next_dc_wr_used;
            dc_rd_full  <= next_dc_rd_full;
            dc_rd_empty <= next_dc_rd_empty;
            dc_rd_used  <= next_dc_rd_used;
            dc_rd_data  <= next_dc_q;
        end
    end

endmodule
`default_nettype wire

// ### verif/fsl_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsl_defines.svh"
module fsl_chk (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               sc_wr_req,
    input wire logic               sc_rd_req,
    input wire logic               sc_full,
    input wire logic               sc_empty,
    input wire logic [`FSL_PW-1:0] sc_used,
    input wire logic               dc_wr_req,
    input wire logic               dc_wr_empty,
    input wire logic [`FSL_PW-1:0] dc_wr_used,
    input wire logic               dc_rd_req,
    input wire logic               dc_rd_full,
    input wire logic               dc_rd_empty,
    input wire logic [`FSL_PW-1:0] dc_rd_used
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Write-side empty high means no word is in flight, so the crossing delays start clean
    sequence dc_fresh;
        dc_wr_req && dc_wr_empty && dc_rd_empty;
    endsequence
    chk_full_on_eighth: assert property (sc_wr_req && !sc_rd_req && sc_used == 4'h7 |=> sc_full)
        else $error("full flag late");
    chk_used_counts_up: assert property (sc_wr_req && !sc_rd_req && !sc_full |=> sc_used == $past(sc_used) + 4'h1)
        else $error("word count did not rise");
    chk_last_read_empties: assert property (sc_rd_req && !sc_wr_req && !sc_empty && sc_used == 4'h1 |=> sc_empty)
        else $error("empty late after last read");
    chk_dc_wr_empty: assert property (dc_wr_req && dc_wr_empty |=> !dc_wr_empty)
        else $error("write side empty late");
    chk_dc_wr_level: assert property (dc_wr_req && dc_wr_empty |-> ##2 dc_wr_used == 4'h1)
        else $error("write side level wrong");
    chk_dc_rd_empty: assert property (dc_fresh |=> dc_rd_empty [*3] ##1 !dc_rd_empty)
        else $error("read side empty timing wrong");
    chk_dc_rd_level: assert property (dc_fresh |-> ##4 dc_rd_used == 4'h0 ##1 dc_rd_used == 4'h1)
        else $error("read side level timing wrong");
    chk_dc_rd_full: assert property (dc_rd_req && dc_rd_full |=> !dc_rd_full)
        else $error("read side full stuck");
    cover property (sc_full ##1 !sc_full);
    cover property (dc_rd_req && dc_rd_full);
    cover property (sc_wr_req && sc_rd_req && !sc_empty);
endmodule
bind fsl_fifo_latency fsl_chk u_chk (
    .pclk(pclk), .presetn(presetn), .sc_wr_req(sc_wr_req), .sc_rd_req(sc_rd_req),
    .sc_full(sc_full), .sc_empty(sc_empty), .sc_used(sc_used), .dc_wr_req(dc_wr_req),
    .dc_wr_empty(dc_wr_empty), .dc_wr_used(dc_wr_used), .dc_rd_req(dc_rd_req),
    .dc_rd_full(dc_rd_full), .dc_rd_empty(dc_rd_empty), .dc_rd_used(dc_rd_used)
);
`default_nettype wire

// ### verif/fsl_peer.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsl_defines.svh"
module fsl_peer (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          want_wr,
    input  wire logic          want_rd,
    input  wire logic          bold,
    input  wire logic          full,
    input  wire logic          empty,
    output logic               wr_req,
    output logic [`FSL_DW-1:0] wr_data,
    output logic               rd_req
);
    logic [`FSL_DW-1:0] cnt;
    logic [`FSL_DW-1:0] next_cnt;
    // Bold mode breaks the flag duty on purpose, only while the guards are on
    assign wr_req = want_wr && (!full || bold);
    assign rd_req = want_rd && (!empty || bold);
    // Idle data is inverted so a stale word never looks fresh
    assign wr_data = wr_req ? cnt : ~cnt;
    always_comb next_cnt = wr_req ? cnt + 8'h3b : cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt <= 8'h11;
        else
            cnt <= next_cnt;
    end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsl_defines.svh"
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pf = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] ww = 2'h0, wr = 2'h0, bold = 2'h0, pend = 2'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, dwe, drf;
    wire logic [1:0] wq, rq, full, empty;
    wire logic [7:0] wd [2];
    wire logic [7:0] rdd [2];
    wire logic [3:0] scu, dwu, dru;
    logic [7:0] q [2][$];
    int error_cnt = 0, checked = 0;
    always #50 pclk = ~pclk;
    fsl_fifo_latency uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sc_wr_req(wq[0]), .sc_wr_data(wd[0]), .sc_rd_req(rq[0]), .sc_rd_data(rdd[0]),
        .sc_full(full[0]), .sc_empty(empty[0]), .sc_used(scu), .dc_wr_req(wq[1]),
        .dc_wr_data(wd[1]), .dc_wr_full(full[1]), .dc_wr_empty(dwe), .dc_wr_used(dwu),
        .dc_rd_req(rq[1]), .dc_rd_data(rdd[1]), .dc_rd_full(drf), .dc_rd_empty(empty[1]),
        .dc_rd_used(dru)
    );
    for (genvar i = 0; i < 2; i++) begin : g_peer
        fsl_peer u_peer (.pclk(pclk), .presetn(presetn), .want_wr(ww[i]), .want_rd(wr[i]),
            .bold(bold[i]), .full(full[i]), .empty(empty[i]), .wr_req(wq[i]), .wr_data(wd[i]),
            .rd_req(rq[i]));
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = pslverr ? 32'hffff_ffff : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    task automatic idle_status();
        logic [31:0] r;
        apb(1'b1, 12'h004, 32'hffff_ffff, r);
        apb(1'b0, 12'h004, 32'h0, r);
        check("single status", 32'h10, r);
        apb(1'b0, 12'h008, 32'h0, r);
        check("dual status", 32'h410, r);
    endtask
    // Reads of normal mode are judged one edge later, prefetch reads at the edge itself
    always @(posedge pclk) begin
        for (int i = 0; i < 2; i++) begin
            if (pend[i])
                check("read data", {24'h0, q[i].pop_front()}, {24'h0, rdd[i]});
            pend[i] = 1'b0;
            if (wq[i] && !full[i])
                q[i].push_back(wd[i]);
            if (rq[i] && !empty[i] && pf)
                check("head data", {24'h0, q[i].pop_front()}, {24'h0, rdd[i]});
            else if (rq[i] && !empty[i])
                pend[i] = 1'b1;
        end
    end
    initial begin
        logic [31:0] r;
        int s, d;
        void'($urandom(87390));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h00c, 32'h0, r);
        check("unmapped read", 32'hffff_ffff, r);
        idle_status();
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, 12'h000, {27'h0, m[2], 2'b00, m[1], m[0]}, r);
            apb(1'b0, 12'h000, 32'h0, r);
            check("control", {27'h0, m[2], 2'b00, m[1], m[0]}, r);
            pf <= m[0];
            ww <= 2'b11;
            @(posedge pclk);
            ww <= 2'b00;
            s = 0;
            d = 0;
            for (int c = 1; c < 9; c++) begin
                #1;
                if (empty[0] === 1'b0 && s == 0)
                    s = c;
                if (empty[1] === 1'b0 && d == 0)
                    d = c;
                @(posedge pclk);
            end
            check("single write to empty", 1 + m[0] + m[1], s);
            check("dual write to empty", 2 + `FSL_SYNC_N, d);
            repeat (150) begin
                @(posedge pclk);
                ww <= 2'($urandom) | 2'($urandom);
                wr <= 2'($urandom);
            end
            ww <= 2'b00;
            wr <= 2'b11;
            repeat (40) @(posedge pclk);
            wr <= 2'b00;
            check("drained", 32'h3, {30'h0, empty});
            check("drained words", 32'h0, q[0].size() + q[1].size());
            $display("test mode %0d done", m);
        end
        apb(1'b1, 12'h000, 32'h0000_000c, r);
        // Guards run in normal mode, so reads are judged one edge late again
        pf <= 1'b0;
        bold <= 2'b01;
        ww <= 2'b01;
        repeat (12) @(posedge pclk);
        ww <= 2'b00;
        @(posedge pclk);
        check("guarded fill", 32'h8, {28'h0, scu});
        wr <= 2'b01;
        repeat (15) @(posedge pclk);
        wr <= 2'b00;
        bold <= 2'b00;
        #1;
        check("guarded drain", 32'h0, {28'h0, scu});
        check("guarded words", 32'h0, q[0].size());
        idle_status();
        $display("test guards done");
        report_and_stop();
    end
endmodule
`default_nettype wire
